/* File: ccrs_pkg.sv */
// constants and types of the core register stack
`default_nettype none
package ccrs_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 12;
   localparam int STK_DEPTH = 6;
   localparam int LVL_W = 3;
   localparam logic [LVL_W-1:0] STK_FULL = 3'h6;
   localparam logic [LVL_W-1:0] STK_NONE = 3'h0;
   localparam logic [7:0] ADDR_PTR0 = 8'h80;
   localparam logic [7:0] ADDR_PTR1 = 8'h81;
   localparam logic [7:0] ADDR_SD0 = 8'h82;
   localparam logic [7:0] ADDR_SD1 = 8'h83;
   localparam logic [7:0] ADDR_ACC = 8'hFF;
   localparam int NREG = 5;
   localparam logic [2:0] IDX_ACC = 3'h4;
   localparam logic [2:0] IDX_NONE = 3'h7;
   localparam logic [PC_W-1:0] PC_RESET = 12'hFFE;
   localparam logic [PC_W-1:0] PC_ONE = 12'h001;
   localparam logic [2:0] SD_CYCLES = 3'h4;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

   typedef enum logic [3:0] {
      PC_HOLD = 4'h0, PC_NEXT = 4'h1, PC_REL = 4'h2, PC_JUMP = 4'h3,
      PC_CALL = 4'h4, PC_IRQ = 4'h5, PC_NMI = 4'h6,
      PC_SUB_EXIT = 4'h7, PC_SVC_EXIT = 4'h8
   } ccrs_pc_op_t;

   typedef enum logic [1:0] {
      CTX_NORMAL = 2'h0, CTX_IRQ = 2'h1, CTX_NMI = 2'h2
   } ccrs_ctx_t;

   typedef enum logic {SD_IDLE = 1'h0, SD_BUSY = 1'h1} ccrs_sd_state_t;

   // data-space address to register index
   function automatic logic [2:0] ccrs_reg_index(input logic [7:0] a);
      case (a)
         ADDR_PTR0: ccrs_reg_index = 3'h0;
         ADDR_PTR1: ccrs_reg_index = 3'h1;
         ADDR_SD0: ccrs_reg_index = 3'h2;
         ADDR_SD1: ccrs_reg_index = 3'h3;
         ADDR_ACC: ccrs_reg_index = IDX_ACC;
         default: ccrs_reg_index = IDX_NONE;
      endcase
   endfunction
endpackage
`default_nettype wire

/* File: ccrs_ret_stack.sv */
// six-level return address stack
`default_nettype none
module ccrs_ret_stack
   import ccrs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [PC_W-1:0] push_data_i,
   output logic [PC_W-1:0] top_o,
   output logic empty_o,
   output logic [LVL_W-1:0] level_o
);
   logic [PC_W-1:0] lvl [STK_DEPTH];
   logic [LVL_W-1:0] level;

   // shift deeper on push, toward top on pop; bottom drops off
   always_ff @(posedge clk_i) begin
      if (push_i) begin
         lvl[0] <= push_data_i;
      end else if (pop_i) begin
         lvl[0] <= lvl[1];
      end
   end
   for (genvar i = 1; i < STK_DEPTH; i++) begin : g_lvl
      always_ff @(posedge clk_i) begin
         if (push_i) begin
            lvl[i] <= lvl[i-1];
         end else if (pop_i) begin
            lvl[i] <= (i == STK_DEPTH - 1) ? lvl[i] : lvl[(i+1)%STK_DEPTH];
         end
      end
   end

   // depth saturates both ways, no error reported
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level <= STK_NONE;
      end else if (push_i && level != STK_FULL) begin
         level <= level + CNT_ONE;
      end else if (pop_i && !push_i && level != STK_NONE) begin
         level <= level - CNT_ONE;
      end
   end
   assign top_o = lvl[0];
   assign empty_o = (level == STK_NONE);
   assign level_o = level;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_push_top: assert property (push_i |=> top_o == $past(push_data_i))
      else $error("pushed address not on top");
   a_depth_sat: assert property (level == STK_FULL && push_i |=> level == STK_FULL)
      else $error("stack depth passed six");
   a_pop_empty: assert property (empty_o && pop_i && !push_i |=> empty_o)
      else $error("empty stack moved on pop");
   c_stack_full: cover property (level == STK_FULL && push_i);
endmodule // ccrs_ret_stack
`default_nettype wire

/* File: ccrs_flag_bank.sv */
// banked carry and zero pairs with context tracking
`default_nettype none
module ccrs_flag_bank
   import ccrs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enter_irq_i,
   input wire logic enter_nmi_i,
   input wire logic leave_i,
   input wire logic carry_we_i,
   input wire logic carry_i,
   input wire logic zero_we_i,
   input wire logic zero_i,
   output logic carry_o,
   output logic zero_o,
   output ccrs_ctx_t ctx_o
);
   logic [2:0] carry;
   logic [2:0] zero;
   ccrs_ctx_t ctx;
   ccrs_ctx_t saved0;
   ccrs_ctx_t saved1;
   ccrs_ctx_t next_ctx;
   logic [2:0] next_carry;
   logic [2:0] next_zero;

   always_comb begin
      next_ctx = ctx;
      if (enter_nmi_i) begin
         next_ctx = CTX_NMI;
      end else if (enter_irq_i) begin
         next_ctx = CTX_IRQ;
      end else if (leave_i) begin
         next_ctx = saved0;
      end
   end

   // only the active pair is touched; switching never clears
   for (genvar i = 0; i < 3; i++) begin : g_pair
      always_comb begin
         next_carry[i] = carry[i];
         next_zero[i] = zero[i];
         if (ctx == ccrs_ctx_t'(i)) begin
            if (carry_we_i) next_carry[i] = carry_i;
            if (zero_we_i) next_zero[i] = zero_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carry <= 3'h0;
         zero <= 3'h0;
         carry_o <= 1'h0;
         zero_o <= 1'h0;
      end else begin
         carry <= next_carry;
         zero <= next_zero;
         carry_o <= next_carry[next_ctx];
         zero_o <= next_zero[next_ctx];
      end
   end

   // two saved contexts; leaving with none saved returns to normal
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctx <= CTX_NMI;
         saved0 <= CTX_NORMAL;
         saved1 <= CTX_NORMAL;
      end else begin
         ctx <= next_ctx;
         if (enter_nmi_i || enter_irq_i) begin
            saved0 <= ctx;
            saved1 <= saved0;
         end else if (leave_i) begin
            saved0 <= saved1;
            saved1 <= CTX_NORMAL;
         end
      end
   end
   assign ctx_o = ctx;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_irq_enter: assert property (enter_irq_i && !enter_nmi_i |=> ctx == CTX_IRQ)
      else $error("interrupt context not entered");
   a_pair_private: assert property (ctx != CTX_NORMAL |=> carry[0] == $past(carry[0]))
      else $error("normal pair changed outside its context");
   a_pair_kept: assert property (leave_i && !carry_we_i |=> carry == $past(carry))
      else $error("flag pair altered by context switch");
endmodule // ccrs_flag_bank
`default_nettype wire

/* File: cpu_core_register_stack.sv */
// core registers, instruction pointer, flag banks and return stack
//
// Contract
// - 8-bit accumulator also read/written as data location FFh.
// - two pointer registers mapped at data addresses 80h and 81h.
// - two short-direct registers mapped at 82h and 83h.
// - short-direct access completes in four cycles; pointers usable too.
// - 12-bit instruction pointer spans 4096 program bytes.
// - ordinary instruction advances the pointer by one.
// - relative branch adds signed offset to the pointer.
// - jump/call load target, interrupt vector, reset vector, returns pop.
// - three carry/zero pairs: normal, interrupt, non-maskable.
// - interrupt entry switches pair; service exit restores previous pair.
// - pairs keep their contents across context switches.
// - a pair is reachable only in its own context.
// - carry from arithmetic, tested bit, and rotate-left input.
// - zero set when last result is zero, else cleared.
// - reset starts in non-maskable context.
// - return stack holds six 12-bit entries outside data space.
// - call or interrupt pushes pointer, deepest entry lost.
// - return pops top into pointer, entries move up.
// - beyond six nestings stack stays deepest silently.
// - return on empty stack stays put, runs next instruction.
// - pointer and short-direct registers have no reset value.
`default_nettype none
module cpu_core_register_stack
   import ccrs_pkg::*;
#(
   parameter logic [ccrs_pkg::PC_W-1:0] RESET_VECTOR = ccrs_pkg::PC_RESET
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic [7:0] DS_ADDR_I,
   input wire logic [ccrs_pkg::DATA_W-1:0] DS_WDATA_I,
   input wire logic DS_WR_I,
   input wire logic DS_RD_I,
   output logic [ccrs_pkg::DATA_W-1:0] DS_RDATA_O,
   output logic DS_HIT_O,
   input wire logic SD_START_I,
   input wire logic [1:0] SD_SEL_I,
   input wire logic SD_WE_I,
   input wire logic [ccrs_pkg::DATA_W-1:0] SD_WDATA_I,
   output logic SD_DONE_O,
   output logic [ccrs_pkg::DATA_W-1:0] SD_RDATA_O,
   input wire logic ACC_WE_I,
   input wire logic [ccrs_pkg::DATA_W-1:0] ACC_WDATA_I,
   output logic [ccrs_pkg::DATA_W-1:0] ACC_O,
   input wire ccrs_pkg::ccrs_pc_op_t PC_OP_I,
   input wire logic [ccrs_pkg::PC_W-1:0] TARGET_I,
   input wire logic [ccrs_pkg::DATA_W-1:0] OFFSET_I,
   output logic [ccrs_pkg::PC_W-1:0] PC_O,
   input wire logic CARRY_WE_I,
   input wire logic CARRY_I,
   input wire logic ZERO_WE_I,
   input wire logic [ccrs_pkg::DATA_W-1:0] RESULT_I,
   output logic CARRY_O,
   output logic ZERO_O,
   output ccrs_pkg::ccrs_ctx_t CONTEXT_O
);
   import ccrs_pkg::*;

   logic [DATA_W-1:0] regs [NREG];
   logic [2:0] wr_idx;
   logic [2:0] rd_idx;
   ccrs_sd_state_t sd_state;
   logic [2:0] sd_cnt;
   logic [1:0] sd_sel;
   logic sd_we;
   logic [DATA_W-1:0] sd_wdata;
   logic sd_commit;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [PC_W-1:0] rel_sum;
   logic [PC_W-1:0] stk_top;
   logic stk_empty;
   logic stk_push;
   logic stk_pop;
   logic is_return;

   assign wr_idx = ccrs_reg_index(DS_ADDR_I);
   assign rd_idx = ccrs_reg_index(DS_ADDR_I);
   assign sd_commit = (sd_state == SD_BUSY) && (sd_cnt == CNT_ZERO);

   // ---------------- data-space registers ----------------
   // no reset: contents are undefined until software writes them
   for (genvar i = 0; i < NREG; i++) begin : g_reg
      always_ff @(posedge CLOCK_I) begin
         if (DS_WR_I && wr_idx == 3'(i)) begin
            regs[i] <= DS_WDATA_I;
         end else if (sd_commit && sd_we && {1'b0, sd_sel} == 3'(i)) begin
            regs[i] <= sd_wdata;
         end else if (3'(i) == IDX_ACC && ACC_WE_I) begin
            regs[i] <= ACC_WDATA_I;
         end
      end
   end
   assign ACC_O = regs[IDX_ACC];

   // registered read port; unmapped addresses answer zero, hit low
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         DS_RDATA_O <= DATA_ZERO;
         DS_HIT_O <= 1'b0;
      end else if (DS_RD_I) begin
         DS_HIT_O <= (rd_idx != IDX_NONE);
         if (rd_idx != IDX_NONE) begin
            DS_RDATA_O <= regs[rd_idx];
         end else begin
            DS_RDATA_O <= DATA_ZERO;
         end
      end else begin
         DS_HIT_O <= 1'b0;
      end
   end

   // ---------------- short-direct sequencer ----------------
   // select 0..3 reaches pointer and short-direct registers alike
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         sd_state <= SD_IDLE;
         sd_cnt <= CNT_ZERO;
         sd_sel <= 2'h0;
         sd_we <= 1'b0;
         sd_wdata <= DATA_ZERO;
      end else begin
         case (sd_state)
            SD_IDLE: begin
               if (SD_START_I) begin
                  sd_state <= SD_BUSY;
                  sd_cnt <= SD_CYCLES - CNT_ONE;
                  sd_sel <= SD_SEL_I;
                  sd_we <= SD_WE_I;
                  sd_wdata <= SD_WDATA_I;
               end
            end
            SD_BUSY: begin
               if (sd_cnt == CNT_ZERO) begin
                  sd_state <= SD_IDLE;
               end else begin
                  sd_cnt <= sd_cnt - CNT_ONE;
               end
            end
            default: sd_state <= SD_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         SD_DONE_O <= 1'b0;
         SD_RDATA_O <= DATA_ZERO;
      end else begin
         SD_DONE_O <= sd_commit;
         if (sd_commit) begin
            SD_RDATA_O <= sd_we ? sd_wdata : regs[{1'b0, sd_sel}];
         end
      end
   end

   // ---------------- instruction pointer ----------------
   assign rel_sum = pc + {{(PC_W-DATA_W){OFFSET_I[DATA_W-1]}}, OFFSET_I};
   assign is_return = (PC_OP_I == PC_SUB_EXIT) || (PC_OP_I == PC_SVC_EXIT);

   always_comb begin
      next_pc = pc;
      case (PC_OP_I)
         PC_HOLD: next_pc = pc;
         PC_NEXT: next_pc = pc + PC_ONE;
         PC_REL: next_pc = rel_sum;
         PC_JUMP: next_pc = TARGET_I;
         PC_CALL: next_pc = TARGET_I;
         PC_IRQ: next_pc = TARGET_I;
         PC_NMI: next_pc = TARGET_I;
         PC_SUB_EXIT, PC_SVC_EXIT: begin
            // empty stack: fall through to the next instruction
            next_pc = stk_empty ? pc + PC_ONE : stk_top;
         end
         default: next_pc = pc;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         pc <= RESET_VECTOR;
      end else begin
         pc <= next_pc;
      end
   end
   assign PC_O = pc;

   // ---------------- return stack ----------------
   // only the pointer goes on the stack, data registers stay put
   assign stk_push = (PC_OP_I == PC_CALL) || (PC_OP_I == PC_IRQ)
      || (PC_OP_I == PC_NMI);
   assign stk_pop = is_return;

   ccrs_ret_stack u_stack (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .push_i(stk_push),
      .pop_i(stk_pop),
      .push_data_i(pc),
      .top_o(stk_top),
      .empty_o(stk_empty),
      .level_o()
   );

   // ---------------- flag pairs ----------------
   ccrs_flag_bank u_flags (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .enter_irq_i(PC_OP_I == PC_IRQ),
      .enter_nmi_i(PC_OP_I == PC_NMI),
      .leave_i(PC_OP_I == PC_SVC_EXIT),
      .carry_we_i(CARRY_WE_I),
      .carry_i(CARRY_I),
      .zero_we_i(ZERO_WE_I),
      .zero_i(RESULT_I == DATA_ZERO),
      .carry_o(CARRY_O),
      .zero_o(ZERO_O),
      .ctx_o(CONTEXT_O)
   );

   // ---------------- checks ----------------
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   a_pc_increment: assert property (PC_OP_I == PC_NEXT |=> PC_O == $past(PC_O) + PC_ONE)
      else $error("pointer did not advance by one");
   a_pc_relative: assert property (PC_OP_I == PC_REL |=> PC_O == $past(rel_sum))
      else $error("relative branch sum wrong");
   a_pc_target: assert property (PC_OP_I inside {PC_JUMP, PC_CALL, PC_IRQ}
      |=> PC_O == $past(TARGET_I))
      else $error("pointer not loaded with target");
   a_ret_empty: assert property (PC_OP_I == PC_SUB_EXIT && stk_empty
      |=> PC_O == $past(PC_O) + PC_ONE)
      else $error("return on empty stack did not fall through");

   property p_call_return;
      logic [PC_W-1:0] saved;
      (PC_OP_I == PC_CALL, saved = PC_O) ##1 (PC_OP_I == PC_SUB_EXIT)
         |=> PC_O == saved;
   endproperty
   a_call_return: assert property (p_call_return)
      else $error("return did not restore call address");

   a_acc_mapped: assert property (DS_WR_I && DS_ADDR_I == ADDR_ACC
      ##1 DS_RD_I && DS_ADDR_I == ADDR_ACC && !DS_WR_I && !ACC_WE_I
      && !sd_commit |=> DS_RDATA_O == $past(DS_WDATA_I, 2))
      else $error("accumulator not readable at its data address");
   a_sd_latency: assert property (sd_state == SD_IDLE && SD_START_I
      |=> !SD_DONE_O [*4] ##1 SD_DONE_O)
      else $error("short-direct access not four cycles");
   a_reset_ctx: assert property ($fell(RST_I) |-> CONTEXT_O == CTX_NMI)
      else $error("reset did not start in non-maskable context");

   c_call_ret: cover property (PC_OP_I == PC_CALL ##1 PC_OP_I == PC_SUB_EXIT);
   c_irq_nest: cover property (PC_OP_I == PC_IRQ ##[1:4] PC_OP_I == PC_NMI);
   c_sd_write: cover property (sd_commit && sd_we);
   c_ret_empty: cover property (is_return && stk_empty);
endmodule // cpu_core_register_stack
`default_nettype wire

/* File: ccrs_ds_master.sv */
// data-space bus master standing in for the core's data side
`default_nettype none
module ccrs_ds_master
   import ccrs_pkg::*;
(
   input wire logic clk_i,
   output logic [7:0] addr_o,
   output logic [ccrs_pkg::DATA_W-1:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [ccrs_pkg::DATA_W-1:0] rdata_i,
   input wire logic hit_i
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // one-cycle write strobe; released data goes to its inverse
   task automatic ds_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
      addr_o = ~a;
   endtask

   // write, then read the same address on the very next cycle
   task automatic ds_write_read(input logic [7:0] a, input logic [7:0] d,
                                output logic [7:0] q);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      q = rdata_i;
   endtask

   // answer is registered, so it is taken one cycle after the strobe
   task automatic ds_read(input logic [7:0] a, output logic [7:0] d,
                          output logic h);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
      h = hit_i;
   endtask
endmodule // ccrs_ds_master
`default_nettype wire

/* File: cpu_core_register_stack_bench.sv */
// self-checking bench for the core register stack
`default_nettype none
module cpu_core_register_stack_bench import ccrs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, rst, ds_wr, ds_rd, ds_hit, sd_start, sd_we, sd_done;
   logic acc_we, carry_we, carry, zero_we, carry_o, zero_o;
   logic [7:0] ds_addr, ds_wdata, ds_rdata, sd_wdata, sd_rdata;
   logic [7:0] acc_wdata, acc, offset, result, rd, hit8;
   logic [1:0] sd_sel;
   logic [11:0] target, pc;
   logic h;
   ccrs_pc_op_t pc_op;
   ccrs_ctx_t ctx;
   int error_cnt, n_checks, cycles, n;

   cpu_core_register_stack i_dut (.CLOCK_I(clk), .RST_I(rst),
      .DS_ADDR_I(ds_addr), .DS_WDATA_I(ds_wdata), .DS_WR_I(ds_wr),
      .DS_RD_I(ds_rd), .DS_RDATA_O(ds_rdata), .DS_HIT_O(ds_hit),
      .SD_START_I(sd_start), .SD_SEL_I(sd_sel), .SD_WE_I(sd_we),
      .SD_WDATA_I(sd_wdata), .SD_DONE_O(sd_done), .SD_RDATA_O(sd_rdata),
      .ACC_WE_I(acc_we), .ACC_WDATA_I(acc_wdata), .ACC_O(acc),
      .PC_OP_I(pc_op), .TARGET_I(target), .OFFSET_I(offset), .PC_O(pc),
      .CARRY_WE_I(carry_we), .CARRY_I(carry), .ZERO_WE_I(zero_we),
      .RESULT_I(result), .CARRY_O(carry_o), .ZERO_O(zero_o),
      .CONTEXT_O(ctx));

   ccrs_ds_master i_bus (.clk_i(clk), .addr_o(ds_addr), .wdata_o(ds_wdata),
      .wr_o(ds_wr), .rd_o(ds_rd), .rdata_i(ds_rdata), .hit_i(ds_hit));

   always #50 clk = ~clk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("unexpected hang at %0t: got %h exp %h", $time, cycles, 0);
         summarize();
      end
   end

   task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_pc(input logic [11:0] exp);
      n_checks++;
      if (pc !== exp) begin
         error_cnt++;
         $display("unexpected pc at %0t: got %h exp %h", $time, pc, exp);
      end
   endtask

   // context, carry and zero as one nibble
   task automatic chk_flags(input logic [3:0] exp);
      n_checks++;
      if ({ctx, carry_o, zero_o} !== exp) begin
         error_cnt++;
         $display("unexpected flags at %0t: got %h exp %h", $time,
                  {ctx, carry_o, zero_o}, exp);
      end
   endtask

   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
   endtask

   task automatic pc_do(input ccrs_pc_op_t op, input logic [11:0] t,
                        input logic [7:0] o);
      @(negedge clk);
      pc_op = op;
      target = t;
      offset = o;
      @(negedge clk);
      pc_op = PC_HOLD;
      target = ~t;
   endtask

   task automatic flag_wr(input logic c, input logic [7:0] r);
      @(negedge clk);
      carry_we = 1'b1;
      zero_we = 1'b1;
      carry = c;
      result = r;
      @(negedge clk);
      carry_we = 1'b0;
      zero_we = 1'b0;
      result = ~r;
   endtask

   task automatic sd_go(input logic [1:0] s, input logic we,
                        input logic [7:0] d);
      @(negedge clk);
      sd_start = 1'b1;
      sd_sel = s;
      sd_we = we;
      sd_wdata = d;
      @(negedge clk);
      sd_start = 1'b0;
      sd_wdata = ~d;
      n = 1;
      while (sd_done !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic test_regs();
      logic [7:0] adr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
      for (int i = 0; i < 5; i++) i_bus.ds_write(adr[i], 8'h11 * (i + 1));
      for (int i = 0; i < 5; i++) begin
         i_bus.ds_read(adr[i], rd, h);
         hit8 = {7'h00, h};
         chk_data(rd, 8'h11 * (i + 1));
         chk_data(hit8, 8'h01);
      end
      chk_data(acc, 8'h55);
      i_bus.ds_write(8'h84, 8'h77);
      i_bus.ds_read(8'h84, rd, h);
      hit8 = {7'h00, h};
      chk_data(rd, 8'h00);
      chk_data(hit8, 8'h00);
      @(negedge clk);
      acc_we = 1'b1;
      acc_wdata = 8'hC3;
      @(negedge clk);
      acc_we = 1'b0;
      i_bus.ds_read(8'hFF, rd, h);
      chk_data(rd, 8'hC3);
      i_bus.ds_write_read(8'hFF, 8'h3E, rd);
      chk_data(rd, 8'h3E);
      chk_data(acc, 8'h3E);
      $display("test regs done");
   endtask

   task automatic test_sd();
      for (int s = 0; s < 4; s++) begin
         i_bus.ds_write(8'h80 + s, 8'hA0 + s);
         sd_go(s[1:0], 1'b0, 8'h00);
         chk_data(8'(n), 8'h05);
         chk_data(sd_rdata, 8'hA0 + s);
      end
      sd_go(2'h2, 1'b1, 8'h3C);
      chk_data(8'(n), 8'h05);
      i_bus.ds_read(8'h82, rd, h);
      chk_data(rd, 8'h3C);
      // second start while busy must be dropped
      @(negedge clk);
      sd_start = 1'b1;
      sd_sel = 2'h3;
      sd_we = 1'b1;
      sd_wdata = 8'h5A;
      @(negedge clk);
      sd_start = 1'b0;
      sd_go(2'h0, 1'b1, 8'h66);
      chk_data(8'(n), 8'h03);
      chk_data(sd_rdata, 8'h5A);
      i_bus.ds_read(8'h80, rd, h);
      chk_data(rd, 8'hA0);
      sd_go(2'h1, 1'b1, 8'h99);
      i_bus.ds_read(8'h83, rd, h);
      chk_data(rd, 8'h5A);
      i_bus.ds_read(8'h81, rd, h);
      chk_data(rd, 8'h99);
      $display("test short direct done");
   endtask

   task automatic test_pc();
      chk_pc(12'hFFE);
      pc_do(PC_NEXT, 12'h000, 8'h00);
      chk_pc(12'hFFF);
      pc_do(PC_NEXT, 12'h000, 8'h00);
      chk_pc(12'h000);
      pc_do(PC_HOLD, 12'h123, 8'h00);
      chk_pc(12'h000);
      pc_do(PC_JUMP, 12'h7F0, 8'h00);
      chk_pc(12'h7F0);
      pc_do(PC_REL, 12'h000, 8'h05);
      chk_pc(12'h7F5);
      pc_do(PC_REL, 12'h000, 8'hFD);
      chk_pc(12'h7F2);
      $display("test pointer done");
   endtask

   task automatic test_flags();
      chk_flags({CTX_NMI, 2'b00});
      flag_wr(1'b1, 8'h00);
      chk_flags({CTX_NMI, 2'b11});
      pc_do(PC_SVC_EXIT, 12'h000, 8'h00);
      chk_flags({CTX_NORMAL, 2'b00});
      flag_wr(1'b1, 8'h5A);
      chk_flags({CTX_NORMAL, 2'b10});
      pc_do(PC_IRQ, 12'hFF0, 8'h00);
      chk_pc(12'hFF0);
      chk_flags({CTX_IRQ, 2'b00});
      flag_wr(1'b0, 8'h00);
      chk_flags({CTX_IRQ, 2'b01});
      pc_do(PC_NMI, 12'hFFC, 8'h00);
      chk_flags({CTX_NMI, 2'b11});
      pc_do(PC_SVC_EXIT, 12'h000, 8'h00);
      chk_flags({CTX_IRQ, 2'b01});
      chk_pc(12'hFF0);
      pc_do(PC_SVC_EXIT, 12'h000, 8'h00);
      chk_flags({CTX_NORMAL, 2'b10});
      $display("test flags done");
   endtask

   task automatic test_stack();
      do_reset();
      i_bus.ds_write(8'hFF, 8'hA5);
      for (int i = 0; i < 7; i++) begin
         pc_do(PC_CALL, 12'h100 + 12'(i * 16), 8'h00);
         chk_pc(12'h100 + 12'(i * 16));
      end
      chk_data(acc, 8'hA5);
      for (int i = 5; i >= 0; i--) begin
         pc_do(i[0] ? PC_SVC_EXIT : PC_SUB_EXIT, 12'h000, 8'h00);
         chk_pc(12'h100 + 12'(i * 16));
      end
      pc_do(PC_SUB_EXIT, 12'h000, 8'h00);
      chk_pc(12'h101);
      $display("test stack done");
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      sd_start = 1'b0;
      sd_sel = 2'h0;
      sd_we = 1'b0;
      sd_wdata = 8'h00;
      acc_we = 1'b0;
      acc_wdata = 8'h00;
      pc_op = PC_HOLD;
      target = 12'h000;
      offset = 8'h00;
      carry_we = 1'b0;
      carry = 1'b0;
      zero_we = 1'b0;
      result = 8'h00;
      error_cnt = 0;
      n_checks = 0;
      cycles = 0;
      do_reset();
      test_pc();
      test_regs();
      test_sd();
      test_flags();
      test_stack();
      summarize();
   end
endmodule // cpu_core_register_stack_bench
`default_nettype wire
